//--- verilog/dcwl_pkg.sv
package dcwl_pkg;

    // Serial word and register widths.
    localparam int WORD_W  = 16;
    localparam int HALF_W  = 14;
    localparam int FREQ_W  = 28;
    localparam int PHASE_W = 12;

    // Destination code in the top two bits of a word.
    localparam logic [1:0] DEST_CTRL  = 2'h0;
    localparam logic [1:0] DEST_FREQA = 2'h1;
    localparam logic [1:0] DEST_FREQB = 2'h2;
    localparam logic [1:0] DEST_PHASE = 2'h3;

    // Field positions in a received word.
    localparam int DEST_HI    = 15;
    localparam int DEST_LO    = 14;
    localparam int BIT_FULL   = 13;
    localparam int BIT_HALF   = 12;
    localparam int BIT_FBANK  = 11;
    localparam int BIT_PBANK  = 10;
    localparam int BIT_RSVD   = 9;
    localparam int BIT_CLEAR  = 8;
    localparam int BIT_MODE   = 1;
    localparam int BIT_PHSEL  = 13;

    // Values after system reset: synthesizer held cleared.
    localparam logic [WORD_W-1:0]  CTRL_RESET  = 16'h0100;
    localparam logic [FREQ_W-1:0]  FREQ_RESET  = 28'h0000000;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 12'h000;

    // Master clock cycles from a register update to the synthesis outputs.
    localparam int OUT_LATENCY = 7;

    // Bits per serial word, and bit counter width.
    localparam int           RX_BITS  = 16;
    localparam logic [3:0]   RX_LAST  = 4'hF;
    localparam logic [3:0]   RX_FIRST = 4'h0;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] data;
    } dcwl_rx_t;

    typedef struct packed {
        logic               clear;
        logic               sine_en;
        logic [FREQ_W-1:0]  freq_inc;
        logic [PHASE_W-1:0] phase_off;
    } dcwl_out_t;

    typedef enum logic [1:0] {
        STG_IDLE = 2'b01,
        STG_HELD = 2'b10
    } dcwl_stage_t;

endpackage : dcwl_pkg

//--- verilog/dcwl_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none

module dcwl_serial_rx
    import dcwl_pkg::*;
(
    // Clock and reset.
    input  wire logic    clk,
    input  wire logic    sys_rst,
    // Serial pins.
    input  wire logic    sclk_pin,
    input  wire logic    sdata_pin,
    input  wire logic    frame_sync_n,
    // Received word.
    output var dcwl_rx_t rx_word
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0] sclk_sync;
    logic [1:0] sdata_sync;
    logic [1:0] frame_sync_n_sync;
    logic       sclk_prev;
    logic [3:0] bit_cnt;
    logic [WORD_W-1:0] shift;
    logic       sclk_fall;

    // Pins cross into the master clock domain through two flops each.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_sync  <= 2'h3;
            sdata_sync <= 2'h0;
            frame_sync_n_sync <= 2'h3;
            sclk_prev  <= 1'b1;
        end else begin
            sclk_sync  <= {sclk_sync[0], sclk_pin};
            sdata_sync <= {sdata_sync[0], sdata_pin};
            frame_sync_n_sync <= {frame_sync_n_sync[0], frame_sync_n};
            sclk_prev  <= sclk_sync[1];
        end
    end

    assign sclk_fall = sclk_prev && !sclk_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Data shifts in on serial clock falling edges while the frame is low.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_cnt <= RX_FIRST;
            shift   <= 16'h0000;
            rx_word <= '0;
        end else begin
            rx_word.valid <= 1'b0;
            if (frame_sync_n_sync[1]) begin
                bit_cnt <= RX_FIRST;
            end else if (sclk_fall) begin
                shift   <= {shift[WORD_W-2:0], sdata_sync[1]};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == RX_LAST) begin
                    rx_word.valid <= 1'b1;
                    rx_word.data  <= {shift[WORD_W-2:0], sdata_sync[1]};
                end
            end
        end
    end

    property p_word_on_16th;
        @(posedge clk) disable iff (sys_rst)
        rx_word.valid |-> $past(bit_cnt) == RX_LAST && !$past(frame_sync_n_sync[1]);
    endproperty
    a_word_on_16th: assert property (p_word_on_16th) else $error("Word without 16 edges.");

endmodule : dcwl_serial_rx

`default_nettype wire

//--- verilog/dcwl_loader.sv
// Operation
// - Output starts eight cycles after release.
// - Reset bit clears synthesis state to midscale.
// - Reset bit leaves word registers untouched.
// - Word change reaches output in seven-eight cycles.
// - Control bits sampled one stage late, except mode.
// - Top bits zero route word to control.
// - Full load: low half first, high second.
// - Full load commits only after both halves.
// - Split mode: halves update independently.
// - Half select picks half; ignored in full load.
// - Frequency bank bit selects increment register.
// - Phase bank bit selects offset register.
// - Sixteen-bit words shift on falling serial edges.
// - Reset bit one clears, zero runs.
// - Mode bit enables sine table, unsampled.
`timescale 1ns/1ps
`default_nettype none

module dcwl_loader
    import dcwl_pkg::*;
#(
    parameter int LATENCY = OUT_LATENCY
) (
    // Clock and reset.
    input  wire logic     clk,
    input  wire logic     sys_rst,
    // Serial link pins.
    input  wire logic     sclk_pin,
    input  wire logic     sdata_pin,
    input  wire logic     frame_sync_n,
    // Synthesis datapath controls.
    output var dcwl_out_t synth_out
);

    ////////////////////////////////////////////////////////////////////////////////
    dcwl_rx_t           rx_word;
    logic [WORD_W-1:0]  synth_control_word;
    logic [WORD_W-1:0]  ctrl_applied;
    logic [FREQ_W-1:0]  freq_word_a;
    logic [FREQ_W-1:0]  freq_word_b;
    logic [PHASE_W-1:0] phase_offset_a;
    logic [PHASE_W-1:0] phase_offset_b;
    logic [HALF_W-1:0]  staged_low;
    logic [1:0]         staged_dest;
    dcwl_stage_t        stage_state;
    dcwl_out_t          sel;
    dcwl_out_t          delay_line [LATENCY];

    logic [1:0]         dest;
    logic [HALF_W-1:0]  data14;
    logic               full_word_load;
    logic               half_word_select;
    logic               freq_write;
    logic               second_half;

    dcwl_serial_rx u_rx (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sclk_pin     (sclk_pin),
        .sdata_pin    (sdata_pin),
        .frame_sync_n (frame_sync_n),
        .rx_word      (rx_word)
    );

    assign dest             = rx_word.data[DEST_HI:DEST_LO];
    assign data14           = rx_word.data[HALF_W-1:0];
    assign full_word_load   = synth_control_word[BIT_FULL];
    assign half_word_select = synth_control_word[BIT_HALF];
    assign freq_write       = rx_word.valid && (dest == DEST_FREQA || dest == DEST_FREQB);
    assign second_half      = stage_state == STG_HELD && staged_dest == dest;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register. The reset bit does not touch it, only words do.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            synth_control_word <= CTRL_RESET;
        end else if (rx_word.valid && dest == DEST_CTRL) begin
            synth_control_word <= {DEST_CTRL, rx_word.data[HALF_W-1:0]};
        end
    end

    // Second sampling stage stands in for the falling-edge sample; the mode
    // bit bypasses it, so it leads the other bits by one cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_applied <= CTRL_RESET;
        end else begin
            ctrl_applied <= synth_control_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Staging of the low half in full load mode.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage_state <= STG_IDLE;
            staged_low  <= 14'h0000;
            staged_dest <= DEST_CTRL;
        end else if (freq_write && full_word_load) begin
            if (second_half) begin
                stage_state <= STG_IDLE;
            end else begin
                // A mismatched address restarts the pair rather than mixing words.
                stage_state <= STG_HELD;
                staged_low  <= data14;
                staged_dest <= dest;
            end
        end else if (freq_write) begin
            stage_state <= STG_IDLE;
        end
    end

    // Frequency registers; the generate gives each bank the same loader.
    for (genvar g = 0; g < 2; g++) begin : g_freq
        localparam logic [1:0] MY_DEST = g == 0 ? DEST_FREQA : DEST_FREQB;
        logic [FREQ_W-1:0] word;
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                word <= FREQ_RESET;
            end else if (freq_write && dest == MY_DEST) begin
                if (full_word_load) begin
                    if (second_half) begin
                        word <= {data14, staged_low};
                    end
                end else if (half_word_select) begin
                    word[FREQ_W-1:HALF_W] <= data14;
                end else begin
                    word[HALF_W-1:0] <= data14;
                end
            end
        end
    end
    assign freq_word_a = g_freq[0].word;
    assign freq_word_b = g_freq[1].word;

    // Phase registers; bit 13 of a phase word picks the bank.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_offset_a <= PHASE_RESET;
            phase_offset_b <= PHASE_RESET;
        end else if (rx_word.valid && dest == DEST_PHASE) begin
            if (rx_word.data[BIT_PHSEL]) begin
                phase_offset_b <= rx_word.data[PHASE_W-1:0];
            end else begin
                phase_offset_a <= rx_word.data[PHASE_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        sel.clear     = ctrl_applied[BIT_CLEAR];
        sel.sine_en   = synth_control_word[BIT_MODE];
        sel.freq_inc  = ctrl_applied[BIT_FBANK] ? freq_word_b : freq_word_a;
        sel.phase_off = ctrl_applied[BIT_PBANK] ? phase_offset_b : phase_offset_a;
    end

    // Fixed delay to the datapath; together with the sampling stage a
    // control change lands in seven or eight cycles.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < LATENCY; i++) begin
                delay_line[i] <= '{clear: 1'b1, sine_en: 1'b0, freq_inc: FREQ_RESET,
                                   phase_off: PHASE_RESET};
            end
        end else begin
            delay_line[0] <= sel;
            for (int i = 1; i < LATENCY; i++) begin
                delay_line[i] <= delay_line[i-1];
            end
        end
    end
    assign synth_out = delay_line[LATENCY-1];

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_first_half;
        freq_write && dest == DEST_FREQA && full_word_load && stage_state == STG_IDLE;
    endsequence

    sequence s_second_half;
        freq_write && dest == DEST_FREQA && full_word_load && second_half;
    endsequence

    property p_release_latency;
        @(posedge clk) disable iff (sys_rst)
        $fell(synth_control_word[BIT_CLEAR]) && !$past(sys_rst)
            |-> ##7 synth_out.clear ##1 !synth_out.clear;
    endproperty
    a_release_latency: assert property (p_release_latency) else $error("Release latency.");

    property p_clear_hold;
        @(posedge clk) disable iff (sys_rst)
        synth_control_word[BIT_CLEAR] [*8] |=> synth_out.clear;
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("Clear not held.");

    property p_regs_kept;
        @(posedge clk) disable iff (sys_rst)
        rx_word.valid && dest == DEST_CTRL
            |=> $stable(freq_word_a) && $stable(freq_word_b) && $stable(phase_offset_a)
                && $stable(phase_offset_b);
    endproperty
    a_regs_kept: assert property (p_regs_kept) else $error("Control write touched words.");

    property p_freq_latency;
        @(posedge clk) disable iff (sys_rst)
        $changed(freq_word_a) && !ctrl_applied[BIT_FBANK] && !synth_control_word[BIT_FBANK]
            && !$past(sys_rst)
            |-> ##7 synth_out.freq_inc == $past(freq_word_a, 7);
    endproperty
    a_freq_latency: assert property (p_freq_latency) else $error("Frequency latency.");

    property p_ctrl_route;
        @(posedge clk) disable iff (sys_rst)
        rx_word.valid && dest == DEST_CTRL
            |=> synth_control_word[HALF_W-1:0] == $past(rx_word.data[HALF_W-1:0]);
    endproperty
    a_ctrl_route: assert property (p_ctrl_route) else $error("Control word lost.");

    property p_full_no_partial;
        @(posedge clk) disable iff (sys_rst)
        s_first_half |=> $stable(freq_word_a) && stage_state == STG_HELD;
    endproperty
    a_full_no_partial: assert property (p_full_no_partial) else $error("Half value exposed.");

    property p_full_commit;
        @(posedge clk) disable iff (sys_rst)
        s_second_half |=> freq_word_a == {$past(data14), $past(staged_low)};
    endproperty
    a_full_commit: assert property (p_full_commit) else $error("Full load wrong.");

    property p_split_high;
        @(posedge clk) disable iff (sys_rst)
        freq_write && dest == DEST_FREQB && !full_word_load && half_word_select
            |=> freq_word_b[HALF_W-1:0] == $past(freq_word_b[HALF_W-1:0])
                && freq_word_b[FREQ_W-1:HALF_W] == $past(data14);
    endproperty
    a_split_high: assert property (p_split_high) else $error("Split write wrong.");

    property p_stage_kept;
        @(posedge clk) disable iff (sys_rst)
        stage_state == STG_HELD && rx_word.valid && dest == DEST_CTRL |=> stage_state == STG_HELD;
    endproperty
    a_stage_kept: assert property (p_stage_kept) else $error("Staged half dropped.");

    property p_mode_bypass;
        @(posedge clk) disable iff (sys_rst)
        !$past(sys_rst, 7) |-> synth_out.sine_en == $past(synth_control_word[BIT_MODE], 7);
    endproperty
    a_mode_bypass: assert property (p_mode_bypass) else $error("Mode bit latency.");

endmodule : dcwl_loader

`default_nettype wire

//--- sim/dcwl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module dcwl_host_model
    import dcwl_pkg::*;
(
    // Serial link pins.
    output var logic sclk_pin,
    output var logic sdata_pin,
    output var logic frame_sync_n
);

    initial begin
        sclk_pin     = 1'b1;
        sdata_pin    = 1'b0;
        frame_sync_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Sends nbits of {w0, w1} MSB first in one frame, 64 ns per serial clock period.
    // The serial clock stands high outside frames, so it is high whenever the frame opens.
    task automatic frame(input logic [WORD_W-1:0] w0,
                         input logic [WORD_W-1:0] w1,
                         input int                nbits);
        logic [2*WORD_W-1:0] sr;
        sr = {w0, w1};
        frame_sync_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdata_pin <= sr[2*WORD_W-1-i];
            #32 sclk_pin <= 1'b0;
            #32 sclk_pin <= 1'b1;
        end
        #32 frame_sync_n <= 1'b1;
        // The released data line must not keep showing the last bit.
        sdata_pin <= ~sdata_pin;
        // A short high on the frame sync could slip past the synchroniser and leave
        // the bit count of a cut word standing, so keep an idle gap.
        #64;
    endtask : frame

endmodule : dcwl_host_model

`default_nettype wire

//--- sim/test_dds_control_word_loader.sv
`timescale 1ns/1ps
`default_nettype none

module test_dds_control_word_loader
    import dcwl_pkg::*;
    ;

    logic              clk         = 1'b0;
    logic              sys_rst     = 1'b1;
    wire logic         sclk_pin;
    wire logic         sdata_pin;
    wire logic         frame_sync_n;
    dcwl_out_t         synth_out;
    dcwl_out_t         prev;
    dcwl_out_t         q[$];
    dcwl_out_t         last        = '{1'b1, 1'b0, FREQ_RESET, PHASE_RESET};
    int                n_fail      = 0;
    int                checks_done = 0;
    int                seed        = 23;
    logic [WORD_W-1:0] rw;
    logic [HALF_W-1:0] ctl         = CTRL_RESET[HALF_W-1:0];
    logic [FREQ_W-1:0] fa          = FREQ_RESET;
    logic [FREQ_W-1:0] fb          = FREQ_RESET;
    logic [PHASE_W-1:0] pa         = PHASE_RESET;
    logic [PHASE_W-1:0] pb         = PHASE_RESET;
    logic              stg         = 1'b0;
    logic [1:0]        sdest       = DEST_CTRL;
    logic [HALF_W-1:0] slow        = '0;

    always #2.5 clk = ~clk;

    dcwl_loader #(.LATENCY(OUT_LATENCY)) dut (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sclk_pin     (sclk_pin),
        .sdata_pin    (sdata_pin),
        .frame_sync_n (frame_sync_n),
        .synth_out    (synth_out)
    );

    dcwl_host_model host (
        .sclk_pin     (sclk_pin),
        .sdata_pin    (sdata_pin),
        .frame_sync_n (frame_sync_n)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic note_fail(input string msg);
        n_fail++;
        $display("CHECK FAILED at %0t: %0s", $time, msg);
    endtask : note_fail

    task automatic check_out(input dcwl_out_t got, input dcwl_out_t exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: output %h expected %h", $time, got, exp);
        end
    endtask : check_out

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reference of the word registers; queues each output value the word should produce.
    task automatic apply(input logic [WORD_W-1:0] w);
        logic [FREQ_W-1:0] nv;
        dcwl_out_t         e;
        dcwl_out_t         m;
        nv = (w[DEST_HI:DEST_LO] == DEST_FREQA) ? fa : fb;
        case (w[DEST_HI:DEST_LO])
            DEST_CTRL: ctl = w[HALF_W-1:0];
            DEST_PHASE: begin
                if (w[BIT_PHSEL]) pb = w[PHASE_W-1:0];
                else pa = w[PHASE_W-1:0];
            end
            default: begin
                if (!ctl[BIT_FULL]) begin
                    stg = 1'b0;
                    if (ctl[BIT_HALF]) nv[FREQ_W-1:HALF_W] = w[HALF_W-1:0];
                    else nv[HALF_W-1:0] = w[HALF_W-1:0];
                end else if (stg && sdest == w[DEST_HI:DEST_LO]) begin
                    stg = 1'b0;
                    nv = {w[HALF_W-1:0], slow};
                end else begin
                    stg = 1'b1;
                    sdest = w[DEST_HI:DEST_LO];
                    slow = w[HALF_W-1:0];
                end
                if (w[DEST_HI:DEST_LO] == DEST_FREQA) fa = nv;
                else fb = nv;
            end
        endcase
        e.clear     = ctl[BIT_CLEAR];
        e.sine_en   = ctl[BIT_MODE];
        e.freq_inc  = ctl[BIT_FBANK] ? fb : fa;
        e.phase_off = ctl[BIT_PBANK] ? pb : pa;
        // The mode bit skips the sampling stage, so it lands one cycle ahead of the rest.
        m = last;
        m.sine_en = e.sine_en;
        if (m !== last && m !== e) q.push_back(m);
        if (e !== last) q.push_back(e);
        last = e;
    endtask : apply

    task automatic tx(input string name, input logic [WORD_W-1:0] w0,
                      input logic [WORD_W-1:0] w1, input int nbits);
        int i;
        if (nbits >= WORD_W) apply(w0);
        if (nbits >= 2*WORD_W) apply(w1);
        @(posedge clk);
        host.frame(w0, w1, nbits);
        for (i = 0; i < 400 && q.size() > 0; i++) @(posedge clk);
        if (q.size() > 0) begin
            note_fail("expected output change missing");
            end_of_test();
        end else begin
            $display("done: %0s", name);
        end
    endtask : tx

    ////////////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (sys_rst) begin
            prev <= synth_out;
        end else if (synth_out !== prev) begin
            prev <= synth_out;
            if (q.size() == 0) note_fail("unexpected output change");
            else check_out(synth_out, q.pop_front());
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 check_out(synth_out, last);
        // The clear bit stays set until the frequency word is known.
        tx("control", 16'h2100, 16'h0000, 16);
        tx("low half", 16'h5555, 16'h2500, 32);
        tx("high half", 16'h6AAA, 16'h0000, 16);
        tx("release", 16'h2000, 16'h0000, 16);
        tx("clear again", 16'h2100, 16'h2000, 32);
        tx("partial", 16'h7FFF, 16'h0000, 8);
        tx("split high", 16'h1000, 16'h7FFF, 32);
        tx("split high b", 16'h9ABC, 16'h0000, 16);
        tx("split low", 16'h0000, 16'h4001, 32);
        tx("bank b", 16'h9234, 16'h0800, 32);
        tx("phase", 16'hCABC, 16'hE123, 32);
        tx("phase b", 16'h0C00, 16'h0C02, 32);
        tx("mode and clear", 16'h0100, 16'h0000, 32);
        tx("full ignores half", 16'h3800, 16'hBFFF, 32);
        tx("commit b", 16'h8001, 16'h0000, 16);
        for (int k = 0; k < 24; k++) begin
            rw = 16'($random(seed));
            if (rw[DEST_HI:DEST_LO] == DEST_CTRL) rw[BIT_RSVD] = 1'b0;
            tx("random", rw, 16'h0000, 16);
        end
        repeat (50) @(posedge clk);
        end_of_test();
    end

endmodule : test_dds_control_word_loader

`default_nettype wire
